// ===== rtl/urp_pkg.sv
// shared constants and types for the serial register port and display scan
package urp_pkg;
  ////////////////////////////////////////////////////////////////////////////
  // timing
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned BIT_RATE_BPS  = 625000;
  localparam int unsigned BIT_CYC       =
    1000000000 / (BIT_RATE_BPS * CLK_PERIOD_NS);
  localparam int unsigned BAUD_W        = 8;
  localparam logic [7:0]  BIT_LAST      = 8'(BIT_CYC - 1);
  localparam logic [7:0]  HALF_LAST     = 8'(BIT_CYC / 2 - 1);
  localparam int unsigned GAP_BITS      = 30;
  localparam int unsigned GAP_CYC       = GAP_BITS * BIT_CYC;
  localparam int unsigned RESP_BITS     = 40;
  localparam int unsigned RESP_CYC      = RESP_BITS * BIT_CYC;
  localparam int unsigned ROW_TIME_NS   = 1000000;
  localparam int unsigned ROW_CYC       = ROW_TIME_NS / CLK_PERIOD_NS;
  ////////////////////////////////////////////////////////////////////////////
  // frame layout
  localparam int unsigned DATA_W    = 16;
  localparam int unsigned SAMPLE_W  = 14;
  localparam int unsigned ADDR_W    = 7;
  localparam int unsigned DIR_BIT   = 7;
  localparam logic [13:0] SAMPLE_MAX = 14'h3FFF;
  ////////////////////////////////////////////////////////////////////////////
  // device register map
  localparam logic [6:0] REG_LATEST = 7'h00;
  localparam logic [6:0] REG_PEAK   = 7'h01;
  localparam logic [6:0] REG_FLOOR  = 7'h02;
  localparam logic [6:0] REG_STATUS = 7'h03;
  localparam logic [6:0] REG_COUNT  = 7'h04;
  localparam logic [6:0] DISP_FIRST = 7'h10;
  localparam logic [6:0] DISP_LAST  = 7'h13;
  localparam int unsigned ST_EIN  = 9;
  localparam int unsigned ST_NPN  = 10;
  localparam int unsigned ST_COV  = 11;
  localparam int unsigned ST_WIN1 = 12;
  localparam int unsigned ST_WIN2 = 13;
  localparam int unsigned DOT_ROW_FIRST = 2;
  localparam int unsigned DOT_ROW_LAST  = 5;
  localparam int unsigned DOT_SRC_OFS   = 2;
  localparam int unsigned DOT_BIT       = 7;
  ////////////////////////////////////////////////////////////////////////////
  // host controller register map
  localparam logic [1:0] HREG_CMD    = 2'h0;
  localparam logic [1:0] HREG_WDATA  = 2'h1;
  localparam logic [1:0] HREG_STATUS = 2'h2;
  localparam logic [1:0] HREG_RDATA  = 2'h3;
  localparam int unsigned HST_BUSY = 0;
  localparam int unsigned HST_DONE = 1;
  localparam int unsigned HST_TMO  = 2;
  ////////////////////////////////////////////////////////////////////////////
  // states
  typedef enum logic [3:0] {
    RX_IDLE  = 4'b0001,
    RX_START = 4'b0010,
    RX_DATA  = 4'b0100,
    RX_STOP  = 4'b1000
  } urp_rx_state_type;
  typedef enum logic [2:0] {
    H_IDLE = 3'b001,
    H_SEND = 3'b010,
    H_RECV = 3'b100
  } urp_host_state_type;
endpackage

// ===== rtl/urp_link_if.sv
// two-wire serial link between host controller and device
`timescale 1ns/10ps
interface urp_link_if;
  logic host_receive_pin;
  logic host_transmit_pin;
  modport dev (input host_receive_pin, output host_transmit_pin);
  modport host (output host_receive_pin, input host_transmit_pin);
endinterface

// ===== rtl/urp_dev.sv
// device end: serial register port, read map and display scanner
//
// Local design decision: strobed register access.
`timescale 1ns/10ps
module urp_dev #(
  parameter int unsigned ROW_CYCLES = urp_pkg::ROW_CYC  // cycles per row
) (
  input  wire logic                           CORE_CLK_I,   // 50 MHz clock
  input  wire logic                           SYS_RST_I,    // async reset
  urp_link_if.dev                             link,         // serial link
  input  wire logic [urp_pkg::SAMPLE_W-1:0]   LIGHT_I,      // sample value
  input  wire logic                           LIGHT_VALID_I,// sample strobe
  input  wire logic [urp_pkg::SAMPLE_W-1:0]   WIN1_LO_I,    // window 1 low
  input  wire logic [urp_pkg::SAMPLE_W-1:0]   WIN1_HI_I,    // window 1 high
  input  wire logic [urp_pkg::SAMPLE_W-1:0]   WIN2_LO_I,    // window 2 low
  input  wire logic [urp_pkg::SAMPLE_W-1:0]   WIN2_HI_I,    // window 2 high
  input  wire logic [urp_pkg::DATA_W-1:0]     EVENT_COUNT_I,// counter value
  input  wire logic                           EXT_INPUT_I,  // external pin
  input  wire logic                           SINK_POL_I,   // polarity pin
  input  wire logic                           COVER_I,      // cover pin
  output logic      [7:0]                     ROW_O,        // row drives
  output logic      [7:0]                     SEGMENT_O     // segment drives
);
  import urp_pkg::*;

  logic             rx_s1_reg, rx_s2_reg;
  urp_rx_state_type rx_st_reg;
  logic [7:0]       rx_baud_reg;
  logic [2:0]       rx_bit_reg;
  logic [7:0]       rx_sh_reg;
  logic             rx_byte_reg, rx_err_reg;
  logic [1:0]       byte_idx_reg;
  logic [6:0]       addr_reg;
  logic [7:0]       lo_reg;
  logic [11:0]      gap_reg;
  logic             rd_go_reg, wr_go_reg;
  logic [19:0]      tx_sh_reg;
  logic [4:0]       tx_left_reg;
  logic [7:0]       tx_baud_reg;
  logic             tx_busy_reg, tx_line_reg;
  logic [2:0]       pin_s1_reg, pin_s2_reg;
  logic [13:0]      latest_reg, peak_reg, floor_reg;
  logic [7:0]       disp_reg [8];
  logic [$clog2(ROW_CYCLES)-1:0] row_div_reg;
  logic [2:0]       row_idx_reg;
  logic             row_step;

  localparam logic [11:0] GAP_LAST = 12'(GAP_CYC - 1);
  // bits shifted after the first start bit: 8+stop, start+8+stop
  localparam logic [4:0]  REPLY_BITS = 5'h13;
  localparam logic [$clog2(ROW_CYCLES)-1:0] ROW_LAST =
    ($clog2(ROW_CYCLES))'(ROW_CYCLES - 1);

  function automatic logic inside_win(input logic [13:0] v, lo, hi);
    return (v >= lo) && (v <= hi);
  endfunction

  function automatic logic [15:0] rd_word(input logic [6:0] a);
    logic [15:0] st;
    st = 16'h0000;
    st[ST_EIN]  = pin_s2_reg[0] ^ pin_s2_reg[1];
    st[ST_NPN]  = pin_s2_reg[1];
    st[ST_COV]  = pin_s2_reg[2];
    st[ST_WIN1] = inside_win(latest_reg, WIN1_LO_I, WIN1_HI_I);
    st[ST_WIN2] = inside_win(latest_reg, WIN2_LO_I, WIN2_HI_I);
    case (a)
      REG_LATEST: return 16'(latest_reg);
      REG_PEAK:   return 16'(peak_reg);
      REG_FLOOR:  return 16'(floor_reg);
      REG_STATUS: return st;
      REG_COUNT:  return EVENT_COUNT_I;
      default:    return 16'h0000;
    endcase
  endfunction

  function automatic logic [7:0] pattern(input logic [2:0] r);
    logic dot;
    dot = 1'b0;
    if (r >= 3'(DOT_ROW_FIRST) && r <= 3'(DOT_ROW_LAST))
      dot = disp_reg[3'(r + 3'(DOT_SRC_OFS))][DOT_BIT];
    return {dot, disp_reg[r][6:0]};
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // input synchronisers
  always_ff @(posedge CORE_CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      rx_s1_reg  <= 1'b1;
      rx_s2_reg  <= 1'b1;
      pin_s1_reg <= 3'h0;
      pin_s2_reg <= 3'h0;
    end else begin
      rx_s1_reg  <= link.host_receive_pin;
      rx_s2_reg  <= rx_s1_reg;
      pin_s1_reg <= {COVER_I, SINK_POL_I, EXT_INPUT_I};
      pin_s2_reg <= pin_s1_reg;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // byte receiver, mid-bit sampling
  always_ff @(posedge CORE_CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      rx_st_reg   <= RX_IDLE;
      rx_baud_reg <= 8'h00;
      rx_bit_reg  <= 3'h0;
      rx_sh_reg   <= 8'h00;
      rx_byte_reg <= 1'b0;
      rx_err_reg  <= 1'b0;
    end else begin
      rx_byte_reg <= 1'b0;
      rx_err_reg  <= 1'b0;
      case (rx_st_reg)
        RX_IDLE: if (!rx_s2_reg) begin
          rx_st_reg   <= RX_START;
          rx_baud_reg <= HALF_LAST;
        end
        RX_START: if (rx_baud_reg != 8'h00) begin
          rx_baud_reg <= rx_baud_reg - 8'h01;
        end else if (rx_s2_reg) begin
          rx_st_reg <= RX_IDLE;
        end else begin
          rx_st_reg   <= RX_DATA;
          rx_baud_reg <= BIT_LAST;
          rx_bit_reg  <= 3'h0;
        end
        RX_DATA: if (rx_baud_reg != 8'h00) begin
          rx_baud_reg <= rx_baud_reg - 8'h01;
        end else begin
          rx_sh_reg   <= {rx_s2_reg, rx_sh_reg[7:1]};
          rx_baud_reg <= BIT_LAST;
          rx_bit_reg  <= rx_bit_reg + 3'h1;
          if (rx_bit_reg == 3'h7)
            rx_st_reg <= RX_STOP;
        end
        RX_STOP: if (rx_baud_reg != 8'h00) begin
          rx_baud_reg <= rx_baud_reg - 8'h01;
        end else begin
          rx_st_reg   <= RX_IDLE;
          rx_byte_reg <= rx_s2_reg;
          rx_err_reg  <= !rx_s2_reg;
        end
        default: rx_st_reg <= RX_IDLE;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // transfer sequencing
  always_ff @(posedge CORE_CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      byte_idx_reg <= 2'h0;
      addr_reg     <= 7'h00;
      lo_reg       <= 8'h00;
      gap_reg      <= 12'h000;
      rd_go_reg    <= 1'b0;
      wr_go_reg    <= 1'b0;
    end else begin
      rd_go_reg <= 1'b0;
      wr_go_reg <= 1'b0;
      if (rx_err_reg) begin
        byte_idx_reg <= 2'h0;
      end else if (rx_byte_reg) begin
        gap_reg <= 12'h000;
        case (byte_idx_reg)
          2'h0: begin
            addr_reg <= rx_sh_reg[ADDR_W-1:0];
            if (rx_sh_reg[DIR_BIT])
              rd_go_reg <= 1'b1;
            else
              byte_idx_reg <= 2'h1;
          end
          2'h1: begin
            lo_reg       <= rx_sh_reg;
            byte_idx_reg <= 2'h2;
          end
          default: begin
            wr_go_reg    <= 1'b1;
            byte_idx_reg <= 2'h0;
          end
        endcase
      end else if (byte_idx_reg != 2'h0) begin
        gap_reg <= gap_reg + 12'h001;
        if (gap_reg == GAP_LAST)
          byte_idx_reg <= 2'h0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // reply transmitter: start, low byte, stop, start, high byte, stop
  always_ff @(posedge CORE_CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      tx_sh_reg   <= 20'h00000;
      tx_left_reg <= 5'h00;
      tx_baud_reg <= 8'h00;
      tx_busy_reg <= 1'b0;
      tx_line_reg <= 1'b1;
    end else if (!tx_busy_reg) begin
      tx_line_reg <= 1'b1;
      if (rd_go_reg) begin : load
        logic [15:0] w;
        w = rd_word(addr_reg);
        tx_busy_reg <= 1'b1;
        tx_line_reg <= 1'b0;
        tx_sh_reg   <= {1'b1, 1'b1, w[15:8], 1'b0, 1'b1, w[7:0]};
        tx_left_reg <= REPLY_BITS;
        tx_baud_reg <= BIT_LAST;
      end
    end else if (tx_baud_reg != 8'h00) begin
      tx_baud_reg <= tx_baud_reg - 8'h01;
    end else if (tx_left_reg != 5'h00) begin
      tx_line_reg <= tx_sh_reg[0];
      tx_sh_reg   <= {1'b1, tx_sh_reg[19:1]};
      tx_left_reg <= tx_left_reg - 5'h01;
      tx_baud_reg <= BIT_LAST;
    end else begin
      tx_busy_reg <= 1'b0;
    end
  end

  assign link.host_transmit_pin = tx_line_reg;

  //////////////////////////////////////////////////////////////////////////
  // light sample tracking
  always_ff @(posedge CORE_CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      latest_reg <= 14'h0000;
      peak_reg   <= 14'h0000;
      floor_reg  <= SAMPLE_MAX;
    end else if (LIGHT_VALID_I) begin
      latest_reg <= LIGHT_I;
      if (LIGHT_I > peak_reg)
        peak_reg <= LIGHT_I;
      if (LIGHT_I < floor_reg)
        floor_reg <= LIGHT_I;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // display registers, bits 6:0 of byte k feed row k, bit 7 of byte k+2 its dot (rows 2-5)
  always_ff @(posedge CORE_CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      for (int i = 0; i < 8; i++)
        disp_reg[i] <= 8'h00;
    end else if (wr_go_reg && addr_reg >= DISP_FIRST &&
                 addr_reg <= DISP_LAST) begin : wr
      logic [1:0] k;
      k = 2'(addr_reg - DISP_FIRST);
      disp_reg[{k, 1'b0}] <= lo_reg;
      disp_reg[{k, 1'b1}] <= rx_sh_reg;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // row scanner
  assign row_step = (row_div_reg == ROW_LAST);

  always_ff @(posedge CORE_CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      row_div_reg <= '0;
      row_idx_reg <= 3'h0;
      ROW_O       <= 8'h01;
      SEGMENT_O   <= 8'h00;
    end else begin
      row_div_reg <= row_step ? '0 : row_div_reg + 1'b1;
      if (row_step) begin
        row_idx_reg <= row_idx_reg + 3'h1;
        ROW_O       <= {ROW_O[6:0], ROW_O[7]};
      end
      SEGMENT_O <= pattern(row_step ? row_idx_reg + 3'h1
                                    : row_idx_reg);
    end
  end
endmodule // urp_dev

// ===== rtl/urp_host.sv
// host end: register-driven controller for the serial register port
`timescale 1ns/10ps
module urp_host (
  input  wire logic                       CORE_CLK_I,   // 50 MHz clock
  input  wire logic                       SYS_RST_I,    // async reset
  urp_link_if.host                        link,         // serial link
  input  wire logic [1:0]                 BUS_ADDR_I,   // register select
  input  wire logic [urp_pkg::DATA_W-1:0] BUS_WDATA_I,  // write data
  input  wire logic                       BUS_WR_I,     // write strobe
  input  wire logic                       BUS_RD_I,     // read strobe
  output logic      [urp_pkg::DATA_W-1:0] BUS_RDATA_O   // read data
);
  import urp_pkg::*;

  urp_host_state_type st_reg;
  logic             rx_s1_reg, rx_s2_reg;
  urp_rx_state_type rx_st_reg;
  logic [7:0]       rx_baud_reg;
  logic [2:0]       rx_bit_reg;
  logic [7:0]       rx_sh_reg;
  logic             rx_byte_reg;
  logic [15:0]      wdata_reg, rdata_reg;
  logic [7:0]       lo_reg;
  logic             got_lo_reg, done_reg, tmo_reg, is_rd_reg;
  logic [29:0]      tx_sh_reg;
  logic [4:0]       tx_left_reg;
  logic [7:0]       tx_baud_reg;
  logic             tx_line_reg;
  logic [11:0]      wait_reg;
  logic             cmd_go;

  localparam logic [11:0] RESP_LAST = 12'(RESP_CYC - 1);
  // bits shifted after the first start bit, read and write transfers
  localparam logic [4:0]  RD_BITS   = 5'h09;
  localparam logic [4:0]  WR_BITS   = 5'h1D;

  assign cmd_go = BUS_WR_I && BUS_ADDR_I == HREG_CMD && st_reg == H_IDLE;

  //////////////////////////////////////////////////////////////////////////
  // byte receiver for replies
  always_ff @(posedge CORE_CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      rx_s1_reg   <= 1'b1;
      rx_s2_reg   <= 1'b1;
      rx_st_reg   <= RX_IDLE;
      rx_baud_reg <= 8'h00;
      rx_bit_reg  <= 3'h0;
      rx_sh_reg   <= 8'h00;
      rx_byte_reg <= 1'b0;
    end else begin
      rx_s1_reg   <= link.host_transmit_pin;
      rx_s2_reg   <= rx_s1_reg;
      rx_byte_reg <= 1'b0;
      case (rx_st_reg)
        RX_IDLE: if (!rx_s2_reg) begin
          rx_st_reg   <= RX_START;
          rx_baud_reg <= HALF_LAST;
        end
        RX_START: if (rx_baud_reg != 8'h00) begin
          rx_baud_reg <= rx_baud_reg - 8'h01;
        end else begin
          rx_st_reg   <= rx_s2_reg ? RX_IDLE : RX_DATA;
          rx_baud_reg <= BIT_LAST;
          rx_bit_reg  <= 3'h0;
        end
        RX_DATA: if (rx_baud_reg != 8'h00) begin
          rx_baud_reg <= rx_baud_reg - 8'h01;
        end else begin
          rx_sh_reg   <= {rx_s2_reg, rx_sh_reg[7:1]};
          rx_baud_reg <= BIT_LAST;
          rx_bit_reg  <= rx_bit_reg + 3'h1;
          if (rx_bit_reg == 3'h7)
            rx_st_reg <= RX_STOP;
        end
        RX_STOP: if (rx_baud_reg != 8'h00) begin
          rx_baud_reg <= rx_baud_reg - 8'h01;
        end else begin
          rx_st_reg   <= RX_IDLE;
          rx_byte_reg <= rx_s2_reg;
        end
        default: rx_st_reg <= RX_IDLE;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // command sequencing and transmitter
  always_ff @(posedge CORE_CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      st_reg      <= H_IDLE;
      tx_sh_reg   <= 30'h00000000;
      tx_left_reg <= 5'h00;
      tx_baud_reg <= 8'h00;
      tx_line_reg <= 1'b1;
      is_rd_reg   <= 1'b0;
      got_lo_reg  <= 1'b0;
      lo_reg      <= 8'h00;
      rdata_reg   <= 16'h0000;
      wait_reg    <= 12'h000;
      tmo_reg     <= 1'b0;
    end else begin
      case (st_reg)
        H_IDLE: if (cmd_go) begin
          st_reg      <= H_SEND;
          is_rd_reg   <= BUS_WDATA_I[DIR_BIT];
          tmo_reg     <= 1'b0;
          tx_line_reg <= 1'b0;
          tx_sh_reg   <= {2'h3, wdata_reg[15:8], 1'b0, 1'b1,
                          wdata_reg[7:0], 1'b0, 1'b1, BUS_WDATA_I[7:0]};
          tx_left_reg <= BUS_WDATA_I[DIR_BIT] ? RD_BITS : WR_BITS;
          tx_baud_reg <= BIT_LAST;
        end
        H_SEND: if (tx_baud_reg != 8'h00) begin
          tx_baud_reg <= tx_baud_reg - 8'h01;
        end else if (tx_left_reg != 5'h00) begin
          tx_line_reg <= tx_sh_reg[0];
          tx_sh_reg   <= {1'b1, tx_sh_reg[29:1]};
          tx_left_reg <= tx_left_reg - 5'h01;
          tx_baud_reg <= BIT_LAST;
        end else begin
          st_reg     <= is_rd_reg ? H_RECV : H_IDLE;
          got_lo_reg <= 1'b0;
          wait_reg   <= 12'h000;
        end
        H_RECV: if (rx_byte_reg) begin
          wait_reg <= 12'h000;
          if (got_lo_reg) begin
            rdata_reg <= {rx_sh_reg, lo_reg};
            st_reg    <= H_IDLE;
          end else begin
            lo_reg     <= rx_sh_reg;
            got_lo_reg <= 1'b1;
          end
        end else if (wait_reg == RESP_LAST) begin
          tmo_reg <= 1'b1;
          st_reg  <= H_IDLE;
        end else begin
          wait_reg <= wait_reg + 12'h001;
        end
        default: st_reg <= H_IDLE;
      endcase
    end
  end

  assign link.host_receive_pin = tx_line_reg;

  //////////////////////////////////////////////////////////////////////////
  // software registers; reply completion wins over clear-on-read
  always_ff @(posedge CORE_CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      wdata_reg   <= 16'h0000;
      done_reg    <= 1'b0;
      BUS_RDATA_O <= 16'h0000;
    end else begin
      if (BUS_WR_I && BUS_ADDR_I == HREG_WDATA)
        wdata_reg <= BUS_WDATA_I;
      if (st_reg == H_RECV && rx_byte_reg && got_lo_reg)
        done_reg <= 1'b1;
      else if (cmd_go || (BUS_RD_I && BUS_ADDR_I == HREG_RDATA))
        done_reg <= 1'b0;
      BUS_RDATA_O <= 16'h0000;
      if (BUS_RD_I) begin
        case (BUS_ADDR_I)
          HREG_WDATA:  BUS_RDATA_O <= wdata_reg;
          HREG_STATUS: begin
            BUS_RDATA_O[HST_BUSY] <= st_reg != H_IDLE;
            BUS_RDATA_O[HST_DONE] <= done_reg;
            BUS_RDATA_O[HST_TMO]  <= tmo_reg;
          end
          HREG_RDATA:  BUS_RDATA_O <= rdata_reg;
          default:     BUS_RDATA_O <= 16'h0000;
        endcase
      end
    end
  end
endmodule // urp_host

// ===== verification/urp_properties.sv
// link timing and display scan checker beside the serial link
`timescale 1ns/10ps
module urp_properties #(
  parameter int unsigned ROW_CYCLES = urp_pkg::ROW_CYC  // cycles per row
) (
  input wire logic       CORE_CLK_I,        // clock
  input wire logic       SYS_RST_I,         // async reset
  input wire logic       host_receive_pin,  // host to device line
  input wire logic       host_transmit_pin, // device to host line
  input wire logic [7:0] ROW_O,             // row drives
  input wire logic [7:0] SEGMENT_O          // segment drives
);
  import urp_pkg::*;
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (SYS_RST_I);
  logic [7:0]  row_prev_reg;
  logic [15:0] dwell_reg;
  logic        seen_reg;
  logic [15:0] rx_low_reg;
  logic [15:0] tx_low_reg;
  logic [9:0]  rx_pos_reg;
  logic [9:0]  tx_pos_reg;
  wire         row_step = ROW_O != row_prev_reg;
  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge CORE_CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      row_prev_reg <= 8'h01;
      dwell_reg    <= 16'h0000;
      seen_reg     <= 1'b0;
    end else begin
      row_prev_reg <= ROW_O;
      dwell_reg    <= row_step ? 16'h0000 : dwell_reg + 16'h0001;
      seen_reg     <= seen_reg | row_step;
    end
  end
  always_ff @(posedge CORE_CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      rx_low_reg <= 16'h0000;
      tx_low_reg <= 16'h0000;
    end else begin
      rx_low_reg <= host_receive_pin ? 16'h0000 : rx_low_reg + 16'h0001;
      tx_low_reg <= host_transmit_pin ? 16'h0000 : tx_low_reg + 16'h0001;
    end
  end
  // position inside a frame, 0 when idle
  always_ff @(posedge CORE_CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      rx_pos_reg <= 10'h000;
      tx_pos_reg <= 10'h000;
    end else begin
      if (rx_pos_reg != 10'h000 || !host_receive_pin) begin
        rx_pos_reg <= (rx_pos_reg == 10'h31F) ? 10'h000 : rx_pos_reg + 10'h001;
      end
      if (tx_pos_reg != 10'h000 || !host_transmit_pin) begin
        tx_pos_reg <= (tx_pos_reg == 10'h31F) ? 10'h000 : tx_pos_reg + 10'h001;
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  sequence start_low_s;
    !host_transmit_pin [*8];
  endsequence
  row_onehot_a: assert property ($onehot(ROW_O))
    else $error("row drive not one-hot");
  row_rotate_a: assert property (row_step |->
    ROW_O == {row_prev_reg[6:0], row_prev_reg[7]})
    else $error("row did not step to the next row");
  row_dwell_a: assert property (row_step && seen_reg |->
    dwell_reg == 16'(ROW_CYCLES - 1)) else $error("row dwell wrong");
  dot_blank_a: assert property ((ROW_O & 8'hC3) != 8'h00 |->
    !SEGMENT_O[7]) else $error("dot lit on a row without dot");
  rx_bit_len_a: assert property ($rose(host_receive_pin) |->
    rx_low_reg % BIT_CYC == 0) else $error("host line bit length");
  tx_bit_len_a: assert property ($rose(host_transmit_pin) |->
    tx_low_reg % BIT_CYC == 0) else $error("device line bit length");
  rx_stop_bit_a: assert property (rx_pos_reg == 10'h2F8 |->
    host_receive_pin) else $error("host frame stop bit low");
  tx_stop_bit_a: assert property (tx_pos_reg == 10'h2F8 |->
    host_transmit_pin) else $error("device frame stop bit low");
  tx_start_low_a: assert property ($fell(host_transmit_pin) |->
    start_low_s) else $error("device low bit too short");
endmodule // urp_properties

// ===== verification/tb_top.sv
// self-checking bench: host controller and device on one link
`timescale 1ns/10ps
module tb_top;
  import urp_pkg::*;
  localparam int unsigned ROWS = 16;
  logic        clk = 1'b0, rst = 1'b1, lv = 1'b0, wr = 1'b0, rd = 1'b0;
  logic        ext = 1'b1, pol = 1'b0, cov = 1'b1;
  logic [13:0] light = '0, w1l = '0, w1h = 14'h000A;
  logic [13:0] w2l = 14'h0064, w2h = 14'h00C8;
  logic [15:0] evc = 16'hBEEF, wd = '0, q, rdata;
  logic [1:0]  ad = '0;
  logic [7:0]  row, segment_outputs;
  int          n_mismatch = 0, comparisons = 0, cyc = 0;
  always #10 clk = ~clk;
  urp_link_if urp_link_if_inst ();
  urp_dev #(.ROW_CYCLES(ROWS)) urp_dev_inst (.CORE_CLK_I(clk),
    .SYS_RST_I(rst), .link(urp_link_if_inst.dev), .LIGHT_I(light),
    .LIGHT_VALID_I(lv), .WIN1_LO_I(w1l), .WIN1_HI_I(w1h), .WIN2_LO_I(w2l),
    .WIN2_HI_I(w2h), .EVENT_COUNT_I(evc), .EXT_INPUT_I(ext),
    .SINK_POL_I(pol), .COVER_I(cov), .ROW_O(row), .SEGMENT_O(segment_outputs));
  urp_host urp_host_inst (.CORE_CLK_I(clk), .SYS_RST_I(rst),
    .link(urp_link_if_inst.host), .BUS_ADDR_I(ad), .BUS_WDATA_I(wd),
    .BUS_WR_I(wr), .BUS_RD_I(rd), .BUS_RDATA_O(rdata));
  urp_properties #(.ROW_CYCLES(ROWS)) urp_properties_inst (
    .CORE_CLK_I(clk), .SYS_RST_I(rst),
    .host_receive_pin(urp_link_if_inst.host_receive_pin),
    .host_transmit_pin(urp_link_if_inst.host_transmit_pin),
    .ROW_O(row), .SEGMENT_O(segment_outputs));
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string nm, input logic [15:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // one strobe cycle, result taken in the following cycle
  task automatic bus(input logic w, input logic [1:0] a, input logic [15:0] d);
    wr <= w;
    rd <= !w;
    ad <= a;
    wd <= d;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b0;
    #1 q = rdata;
    @(posedge clk);
  endtask
  task automatic xfer(input logic [7:0] ab, input logic [15:0] d);
    int n = 0;
    bus(1'b1, HREG_WDATA, d);
    bus(1'b1, HREG_CMD, {8'h00, ab});
    do begin
      bus(1'b0, HREG_STATUS, 16'h0000);
      n++;
    end while (q[HST_BUSY] !== 1'b0 && n < 3000);
    if (n >= 3000) n_mismatch++;
    check("host status", 16'(q[2:0]), {14'h0000, ab[DIR_BIT], 1'h0});
    bus(1'b0, HREG_RDATA, 16'h0000);
  endtask
  task automatic rd_dev(input logic [6:0] a, input logic [15:0] e, string nm);
    xfer({1'b1, a}, 16'h0000);
    check(nm, q, e);
  endtask
  task automatic sample(input logic [13:0] v);
    light <= v;
    lv <= 1'b1;
    @(posedge clk);
    lv <= 1'b0;
    @(posedge clk);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_read_map;
    sample(14'h0064);
    sample(14'h3FFF);
    sample(14'h0005);
    rd_dev(REG_LATEST, 16'h0005, "latest");
    rd_dev(REG_PEAK, 16'h3FFF, "peak");
    rd_dev(REG_FLOOR, 16'h0005, "floor");
    rd_dev(REG_STATUS, 16'h1A00, "status a");
    rd_dev(REG_COUNT, 16'hBEEF, "count");
    rd_dev(DISP_FIRST, 16'h0000, "write only");
    pol <= 1'b1;
    cov <= 1'b0;
    w2l <= 14'h0000;
    rd_dev(REG_STATUS, 16'h3400, "status b");
  endtask
  task automatic t_display;
    logic [7:0] b [8] = '{8'h81, 8'h02, 8'h08, 8'h10,
                          8'h84, 8'h20, 8'h40, 8'h80};
    int n;
    for (int i = 0; i < 4; i++) begin
      xfer({1'b0, 7'(DISP_FIRST + i)}, {b[2*i+1], b[2*i]});
    end
    repeat (ROWS * 9) @(negedge clk);
    for (int r = 0; r < 8; r++) begin
      n = 0;
      while (row !== 8'(1 << r) && n < 200) begin
        @(negedge clk);
        n++;
      end
      if (n >= 200) n_mismatch++;
      check("segments", {8'h00, segment_outputs}, {8'h00,
        (r >= 2 && r <= 5) ? b[r+2][7] : 1'b0, b[r][6:0]});
    end
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 80000) begin
      n_mismatch++;
      wrap_up();
    end
  end
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_read_map();
    t_display();
    wrap_up();
  end
endmodule // tb_top
